/* rtl/axil_reg_port.sv */
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`default_nettype none
module axil_reg_port
   import usb_frame_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Write address and data
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // Write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // Read address and data
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Register side
   output reg_cmd_s               cmd,
   input  wire logic [15:0]       rd_data,
   input  wire logic              rd_hit,
   input  wire logic              wr_hit
);
   logic                  aw_have_q;
   logic                  w_have_q;
   logic [`REG_IDX_W-1:0] aw_idx_q;
   logic [15:0]           wdata_q;
   logic [1:0]            wstrb_q;
   logic                  bvalid_q;
   logic [1:0]            bresp_q;
   logic                  rvalid_q;
   logic [1:0]            rresp_q;
   logic [15:0]           rdata_q;

   wire aw_take = awvalid && awready;
   wire w_take  = wvalid && wready;
   wire ar_take = arvalid && arready;
   wire do_wr   = aw_have_q && w_have_q && !bvalid_q;

   // Hold each half until its partner arrives and the response has drained
   assign awready = !aw_have_q && !bvalid_q;
   assign wready  = !w_have_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = {16'h0000, rdata_q};

   assign cmd.wr     = do_wr;
   assign cmd.wr_idx = aw_idx_q;
   assign cmd.wdata  = wdata_q;
   assign cmd.wstrb  = wstrb_q;
   assign cmd.rd     = ar_take;
   assign cmd.rd_idx = araddr[`REG_IDX_W+1:2];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_idx_q  <= '0;
         wdata_q   <= 16'h0000;
         wstrb_q   <= 2'b00;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= awaddr[`REG_IDX_W+1:2];
         end
         if (w_take)
         begin
            w_have_q <= 1'b1;
            wdata_q  <= wdata[15:0];
            wstrb_q  <= wstrb[1:0];
         end
         if (do_wr)
         begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid_q && bready)
            bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= `RESP_OKAY;
         rdata_q  <= 16'h0000;
      end
      else if (ar_take)
      begin
         rvalid_q <= 1'b1;
         rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         rdata_q  <= rd_hit ? rd_data : 16'h0000;
      end
      else if (rvalid_q && rready)
         rvalid_q <= 1'b0;
   end
endmodule
`default_nettype wire

/* rtl/usb_frame_map.svh */
// Register indices, field positions and reset values of the frame, pull-up and stall slice
`ifndef USB_FRAME_MAP_SVH
`define USB_FRAME_MAP_SVH

`define IDX_FRAME_LOW      32'h5000_1826
`define IDX_FRAME_HIGH     32'h5000_1824
`define IDX_PULLUP_TEST    32'h5000_183E
`define IDX_EP0_CTRL       32'h5000_1840
`define IDX_IRQ_STATUS     32'h5000_1860
`define IDX_IRQ_CLEAR      32'h5000_1862
`define IDX_IRQ_ENABLE     32'h5000_1864

`define REG_IDX_W          10
`define ADDR_W_MIN         12

`define PU_STATUS_BIT      7
`define PU_REDUCED_BIT     6
`define PU_DPLUS_BIT       5
`define PU_TEST_EN_BIT     4
`define PU_DMINUS_BIT      2
`define PU_RCDELAY_BIT     1
`define PU_PROTECT_BIT     0
`define EP0_STALL_BIT      7

`define IRQ_STALL_SENT     0
`define IRQ_SETUP_STALLED  1
`define IRQ_NUM            2

`define RESET_PULLUP       8'h00
`define RESET_EP0          1'b0
`define RESET_IRQ          2'b00
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

/* rtl/usb_frame_pkg.sv */
// Types shared by the frame, pull-up and stall slice
`include "usb_frame_map.svh"
package usb_frame_pkg;
   typedef enum logic [1:0] {TOK_IN, TOK_OUT, TOK_SETUP} token_e;

   typedef struct packed {
      logic   valid;
      token_e kind;
   } token_s;

   typedef struct packed {
      logic                      wr;
      logic [`REG_IDX_W-1:0]     wr_idx;
      logic [15:0]               wdata;
      logic [1:0]                wstrb;
      logic                      rd;
      logic [`REG_IDX_W-1:0]     rd_idx;
   } reg_cmd_s;
endpackage

/* rtl/usb_frame_pullup_ep0_ctrl.sv */
// Frame number readout, pull-up test overrides and endpoint 0 stall control
//
// Notes on behaviour
// - Low byte read returns frame, locks high bits
// - High register shows three live MSBs unless locked
// - Test enable hands switches to test bits
// - D+ test bit: zero closes, one opens
// - D- test bit: zero closes, one opens
// - Reduced test bit: zero closes, one opens
// - Stall bit plus transmit FIFO stalls IN
// - Stall bit plus receive FIFO stalls OUT
// - SETUP tokens never get a STALL
// - Sent STALL sets receive-last and transmit-done
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module usb_frame_pullup_ep0_ctrl
   import usb_frame_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // AXI4-Lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // Frame tracking
   input  wire logic [10:0]       frame_number,
   // Pull-up switches
   input  wire logic              normal_dplus_close,
   input  wire logic              normal_dminus_close,
   input  wire logic              normal_reduced_close,
   input  wire logic              pullup_test_status_bit,
   output logic                   dplus_pullup_switch,
   output logic                   dminus_pullup_switch,
   output logic                   reduced_pullup_switch,
   // Token and handshake engine
   input  wire token_s            token,
   input  wire logic              tx_fifo_enabled,
   input  wire logic              rx_fifo_enabled,
   output logic                   stall_request,
   input  wire logic              stall_sent,
   output logic                   set_rx_last,
   output logic                   set_tx_done,
   // Interrupt
   output logic                   irq
);
   generate
      if (ADDR_W < `ADDR_W_MIN)
         $error("ADDR_W must be at least 12 to decode the register indices");
   endgenerate

   reg_cmd_s              cmd;
   logic [15:0]           rd_data;
   logic [7:0]            pullup_q;
   logic                  stall_bit_q;
   logic                  locked_q;
   logic [2:0]            lock_msbs_q;
   logic                  stall_req_q;
   logic                  set_rx_last_q;
   logic                  set_tx_done_q;
   logic [`IRQ_NUM-1:0]   irq_status_q;
   logic [`IRQ_NUM-1:0]   irq_enable_q;
   logic [`IRQ_NUM-1:0]   irq_event;
   logic                  rd_hit;
   logic                  wr_hit;

   // Register decode on the low index bits only; the printed index is far above the window
   localparam logic [`REG_IDX_W-1:0] I_FL = `REG_IDX_W'(`IDX_FRAME_LOW);
   localparam logic [`REG_IDX_W-1:0] I_FH = `REG_IDX_W'(`IDX_FRAME_HIGH);
   localparam logic [`REG_IDX_W-1:0] I_PU = `REG_IDX_W'(`IDX_PULLUP_TEST);
   localparam logic [`REG_IDX_W-1:0] I_EP = `REG_IDX_W'(`IDX_EP0_CTRL);
   localparam logic [`REG_IDX_W-1:0] I_IS = `REG_IDX_W'(`IDX_IRQ_STATUS);
   localparam logic [`REG_IDX_W-1:0] I_IC = `REG_IDX_W'(`IDX_IRQ_CLEAR);
   localparam logic [`REG_IDX_W-1:0] I_IE = `REG_IDX_W'(`IDX_IRQ_ENABLE);

   axil_reg_port #(.ADDR_W(ADDR_W)) u_port
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .cmd     (cmd),
      .rd_data (rd_data),
      .rd_hit  (rd_hit),
      .wr_hit  (wr_hit)
   );

   wire rd_fl = cmd.rd && cmd.rd_idx == I_FL;
   wire rd_fh = cmd.rd && cmd.rd_idx == I_FH;
   wire rd_pu = cmd.rd_idx == I_PU;
   wire rd_ep = cmd.rd_idx == I_EP;
   wire rd_is = cmd.rd_idx == I_IS;
   wire rd_ie = cmd.rd_idx == I_IE;
   assign rd_hit = rd_fl || rd_fh || rd_pu || rd_ep || rd_is || rd_ie || cmd.rd_idx == I_IC;
   wire wr_fl = cmd.wr_idx == I_FL || cmd.wr_idx == I_FH;
   wire wr_pu = cmd.wr && cmd.wstrb[0] && cmd.wr_idx == I_PU;
   wire wr_ep = cmd.wr && cmd.wstrb[0] && cmd.wr_idx == I_EP;
   wire wr_ic = cmd.wr && cmd.wstrb[0] && cmd.wr_idx == I_IC;
   wire wr_ie = cmd.wr && cmd.wstrb[0] && cmd.wr_idx == I_IE;
   assign wr_hit = wr_fl || cmd.wr_idx == I_PU || cmd.wr_idx == I_EP || cmd.wr_idx == I_IS
                   || cmd.wr_idx == I_IC || cmd.wr_idx == I_IE;

   // High bits seen by software: the held copy after a low-byte read, else live
   wire [2:0] fh_msbs = locked_q ? lock_msbs_q : frame_number[10:8];

   // Test bit 7 is a status input and never stored; reserved bits read zero
   wire [7:0] pu_view = {pullup_test_status_bit, pullup_q[6:4], 1'b0, pullup_q[2:0]};

   // Read mux; frame registers are read-only so their writes only answer OKAY
   assign rd_data = rd_fl ? {8'h00, frame_number[7:0]} :
                    rd_fh ? {13'h0000, fh_msbs} :
                    rd_pu ? {8'h00, pu_view} :
                    rd_ep ? {8'h00, stall_bit_q, 7'h00} :
                    rd_is ? {14'h0000, irq_status_q} :
                    rd_ie ? {14'h0000, irq_enable_q} :
                    16'h0000;

   // Frame high-bit lock: a low read captures, a high read releases
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         locked_q    <= 1'b0;
         lock_msbs_q <= 3'h0;
      end
      else if (rd_fl)
      begin
         locked_q    <= 1'b1;
         lock_msbs_q <= frame_number[10:8];
      end
      else if (rd_fh)
         locked_q <= 1'b0;
   end

   // Writable bits only; bit 3 and bit 7 stay zero in storage
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pullup_q    <= `RESET_PULLUP;
         stall_bit_q <= `RESET_EP0;
      end
      else
      begin
         if (wr_pu)
            pullup_q <= cmd.wdata[7:0] & 8'h77;
         if (wr_ep)
            stall_bit_q <= cmd.wdata[`EP0_STALL_BIT];
      end
   end

   // Pull-up switch outputs, high means closed
   wire test_en = pullup_q[`PU_TEST_EN_BIT];
   assign dplus_pullup_switch   = test_en ? !pullup_q[`PU_DPLUS_BIT]   : normal_dplus_close;
   assign dminus_pullup_switch  = test_en ? !pullup_q[`PU_DMINUS_BIT]  : normal_dminus_close;
   assign reduced_pullup_switch = test_en ? !pullup_q[`PU_REDUCED_BIT] : normal_reduced_close;

   // Stall decision per token; SETUP is never stalled
   wire stall_in  = token.kind == TOK_IN  && tx_fifo_enabled;
   wire stall_out = token.kind == TOK_OUT && rx_fifo_enabled;
   wire stall_now = token.valid && stall_bit_q && (stall_in || stall_out);
   wire setup_hit = token.valid && stall_bit_q && token.kind == TOK_SETUP;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         stall_req_q   <= 1'b0;
         set_rx_last_q <= 1'b0;
         set_tx_done_q <= 1'b0;
      end
      else
      begin
         stall_req_q   <= stall_now;
         set_rx_last_q <= stall_sent;
         set_tx_done_q <= stall_sent;
      end
   end

   assign stall_request = stall_req_q;
   assign set_rx_last   = set_rx_last_q;
   assign set_tx_done   = set_tx_done_q;

   // Sticky interrupt status; a new event outranks a clear in the same cycle
   assign irq_event[`IRQ_STALL_SENT]    = stall_sent;
   assign irq_event[`IRQ_SETUP_STALLED] = setup_hit;

   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_NUM; gi++)
      begin : g_irq
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               irq_status_q[gi] <= 1'b0;
            else if (irq_event[gi])
               irq_status_q[gi] <= 1'b1;
            else if (wr_ic && cmd.wdata[gi])
               irq_status_q[gi] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_enable_q <= `RESET_IRQ;
      else if (wr_ie)
         irq_enable_q <= cmd.wdata[`IRQ_NUM-1:0];
   end

   assign irq = |(irq_status_q & irq_enable_q);

   property p_fl_lock;
      @(posedge aclk) disable iff (!aresetn)
      rd_fl |=> locked_q && lock_msbs_q == $past(frame_number[10:8]);
   endproperty
   a_fl_lock: assert property (p_fl_lock) else $error("low read did not lock high bits");

   property p_lock_hold;
      @(posedge aclk) disable iff (!aresetn)
      locked_q && !rd_fh && !rd_fl |=> locked_q && $stable(lock_msbs_q);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked high bits changed");

   property p_fh_live;
      @(posedge aclk) disable iff (!aresetn)
      rd_fh && !locked_q |=> rvalid && rdata[2:0] == $past(frame_number[10:8])
                             && rdata[15:3] == 13'h0000;
   endproperty
   a_fh_live: assert property (p_fh_live) else $error("high read not live");

   property p_fh_unlock;
      @(posedge aclk) disable iff (!aresetn)
      rd_fh && !rd_fl |=> !locked_q;
   endproperty
   a_fh_unlock: assert property (p_fh_unlock) else $error("high read did not unlock");

   property p_normal;
      @(posedge aclk) disable iff (!aresetn)
      !pullup_q[`PU_TEST_EN_BIT] |-> dplus_pullup_switch == normal_dplus_close
         && dminus_pullup_switch == normal_dminus_close
         && reduced_pullup_switch == normal_reduced_close;
   endproperty
   a_normal: assert property (p_normal) else $error("switches not normal");

   property p_test_sw;
      @(posedge aclk) disable iff (!aresetn)
      wr_pu && cmd.wdata[`PU_TEST_EN_BIT] |=> dplus_pullup_switch == !$past(cmd.wdata[5])
         && dminus_pullup_switch == !$past(cmd.wdata[2])
         && reduced_pullup_switch == !$past(cmd.wdata[6]);
   endproperty
   a_test_sw: assert property (p_test_sw) else $error("test switch wrong");

   property p_stall_in;
      @(posedge aclk) disable iff (!aresetn)
      token.valid && token.kind == TOK_IN && stall_bit_q && tx_fifo_enabled |=> stall_request;
   endproperty
   a_stall_in: assert property (p_stall_in) else $error("IN not stalled");

   property p_stall_out;
      @(posedge aclk) disable iff (!aresetn)
      token.valid && token.kind == TOK_OUT && stall_bit_q && rx_fifo_enabled |=> stall_request;
   endproperty
   a_stall_out: assert property (p_stall_out) else $error("OUT not stalled");

   property p_no_setup;
      @(posedge aclk) disable iff (!aresetn)
      token.valid && token.kind == TOK_SETUP |=> !stall_request;
   endproperty
   a_no_setup: assert property (p_no_setup) else $error("SETUP stalled");

   property p_after_stall;
      @(posedge aclk) disable iff (!aresetn)
      stall_sent |=> set_rx_last && set_tx_done;
   endproperty
   a_after_stall: assert property (p_after_stall) else $error("flags not set");

   property p_set_wins;
      @(posedge aclk) disable iff (!aresetn)
      stall_sent |=> irq_status_q[`IRQ_STALL_SENT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("stall event lost to a clear");

   property p_setup_flag;
      @(posedge aclk) disable iff (!aresetn)
      token.valid && token.kind == TOK_SETUP && stall_bit_q |=> irq_status_q[`IRQ_SETUP_STALLED];
   endproperty
   a_setup_flag: assert property (p_setup_flag) else $error("stalled SETUP not flagged");

   property p_no_stray_stall;
      @(posedge aclk) disable iff (!aresetn)
      !(token.valid && stall_bit_q) |=> !stall_request;
   endproperty
   a_no_stray_stall: assert property (p_no_stray_stall) else $error("stall without cause");

   property p_reserved;
      @(posedge aclk) disable iff (!aresetn)
      rvalid |-> rdata[31:8] == 24'h00_0000 && !(rresp == `RESP_OKAY && rdata[3] && $past(rd_pu));
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   c_frame_pair: cover property (@(posedge aclk) disable iff (!aresetn) rd_fl ##[1:20] rd_fh);
   c_stall: cover property (@(posedge aclk) disable iff (!aresetn) stall_request ##[1:20] stall_sent);
   c_test_on: cover property (@(posedge aclk) disable iff (!aresetn) wr_pu && cmd.wdata[4]);
   c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the frame, pull-up and stall slice
`timescale 1ns/1ps
`default_nettype none
module tb
   import usb_frame_pkg::*;
;
   localparam logic [11:0] adr_low  = 12'h098;
   localparam logic [11:0] adr_high = 12'h090;
   localparam logic [11:0] adr_pu   = 12'h0f8;
   localparam logic [11:0] adr_ep0  = 12'h100;
   localparam logic [11:0] adr_sts  = 12'h180;
   localparam logic [11:0] adr_clr  = 12'h188;
   localparam logic [11:0] adr_ena  = 12'h190;
   localparam logic [11:0] adr_bad  = 12'h7fc;
   localparam logic [1:0]  ok       = 2'b00;
   localparam logic [1:0]  slverr   = 2'b10;

   logic        aclk;
   logic        aresetn;
   logic [11:0] awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [11:0] araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic [10:0] frame_number;
   logic [2:0]  normal_close;
   logic        test_status;
   logic [2:0]  sw;
   token_s      token;
   logic        tx_fifo_enabled;
   logic        rx_fifo_enabled;
   logic        stall_request;
   logic        stall_sent;
   logic        set_rx_last;
   logic        set_tx_done;
   logic        irq;
   int          num_errors;
   int          check_count;
   int          cycles;

   usb_frame_pullup_ep0_ctrl #(.ADDR_W(12)) usb_frame_pullup_ep0_ctrl_inst (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .frame_number, .normal_dplus_close(normal_close[2]),
      .normal_dminus_close(normal_close[1]), .normal_reduced_close(normal_close[0]),
      .pullup_test_status_bit(test_status), .dplus_pullup_switch(sw[2]),
      .dminus_pullup_switch(sw[1]), .reduced_pullup_switch(sw[0]), .token,
      .tx_fifo_enabled, .rx_fifo_enabled, .stall_request, .stall_sent, .set_rx_last,
      .set_tx_done, .irq);

   usb_host_model host_inst (.aclk, .token, .stall_request, .stall_sent, .set_rx_last,
      .set_tx_done);

   always #50 aclk = ~aclk;

   // Cuts a hang short; the full run needs well under 2000 cycles
   always @(posedge aclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         num_errors = num_errors + 1;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Edge first, so strobes dropped by the last transfer never clash
   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {16'h0000, d};
      wstrb <= 4'h3;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rdreg(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      rready <= 1'b0;
      chk(rdata, exp);
      chk({30'h0, rresp}, {30'h0, er});
   endtask

   task automatic t_reset();
      rdreg(adr_pu, 32'h0000_0000, ok);
      rdreg(adr_ep0, 32'h0000_0000, ok);
      rdreg(adr_sts, 32'h0000_0000, ok);
      rdreg(adr_ena, 32'h0000_0000, ok);
      chk({29'h0, sw}, {29'h0, normal_close});
      $display("test reset done");
   endtask

   task automatic t_frame();
      frame_number <= 11'h5a3;
      rdreg(adr_high, 32'h0000_0005, ok);
      rdreg(adr_low, 32'h0000_00a3, ok);
      frame_number <= 11'h2b4;
      rdreg(adr_high, 32'h0000_0005, ok);
      rdreg(adr_high, 32'h0000_0002, ok);
      wr(adr_low, 16'hffff, ok);
      rdreg(adr_low, 32'h0000_00b4, ok);
      $display("test frame done");
   endtask

   task automatic t_pullup();
      logic [15:0] d;
      logic [2:0]  v;
      test_status <= 1'b1;
      normal_close <= 3'b101;
      wr(adr_pu, 16'h0000, ok);
      chk({29'h0, sw}, 32'h0000_0005);
      for (int i = 0; i < 8; i++)
      begin
         v = i[2:0];
         d = {9'h000, v[2], v[1], 1'b1, 1'b0, v[0], 2'b00};
         wr(adr_pu, d, ok);
         chk({29'h0, sw}, {29'h0, ~v[1], ~v[0], ~v[2]});
         rdreg(adr_pu, {24'h0, 1'b1, d[6:0]}, ok);
      end
      wr(adr_pu, 16'hff2c, ok);
      normal_close <= 3'b010;
      rdreg(adr_pu, 32'h0000_00a4, ok);
      chk({29'h0, sw}, 32'h0000_0002);
      $display("test pullup done");
   endtask

   task automatic t_stall();
      token_e k;
      int     s0;
      int     f0;
      logic   exp;
      wr(adr_ep0, 16'hffff, ok);
      rdreg(adr_ep0, 32'h0000_0080, ok);
      for (int i = 0; i < 12; i++)
      begin
         k = token_e'(i % 3);
         tx_fifo_enabled <= ((i / 3) % 2) == 1;
         rx_fifo_enabled <= i >= 6;
         host_inst.reply_gap = (i % 2) * 4;
         s0 = host_inst.stalls_seen;
         f0 = host_inst.flags_seen;
         host_inst.send(k);
         repeat (10) @(posedge aclk);
         exp = (k == TOK_IN && tx_fifo_enabled) || (k == TOK_OUT && rx_fifo_enabled);
         chk(host_inst.stalls_seen - s0, {31'h0, exp});
         chk(host_inst.flags_seen - f0, {31'h0, exp});
      end
      wr(adr_ep0, 16'h0000, ok);
      s0 = host_inst.stalls_seen;
      host_inst.send(TOK_IN);
      repeat (10) @(posedge aclk);
      chk(host_inst.stalls_seen - s0, 32'h0000_0000);
      $display("test stall done");
   endtask

   task automatic t_irq();
      rdreg(adr_sts, 32'h0000_0003, ok);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(adr_ena, 16'h0001, ok);
      chk({31'h0, irq}, 32'h0000_0001);
      wr(adr_clr, 16'h0001, ok);
      rdreg(adr_sts, 32'h0000_0002, ok);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(adr_ena, 16'h0003, ok);
      chk({31'h0, irq}, 32'h0000_0001);
      rdreg(adr_clr, 32'h0000_0000, ok);
      wr(adr_clr, 16'h0002, ok);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(adr_bad, 16'hffff, slverr);
      rdreg(adr_bad, 32'h0000_0000, slverr);
      $display("test irq done");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      frame_number = 11'h000;
      normal_close = 3'b110;
      test_status = 1'b0;
      tx_fifo_enabled = 1'b0;
      rx_fifo_enabled = 1'b0;
      num_errors = 0;
      check_count = 0;
      cycles = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_frame();
      t_pullup();
      t_stall();
      t_irq();
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* verification/usb_host_model.sv */
// Host-side model: sends tokens and answers stall requests with a STALL
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
   import usb_frame_pkg::*;
(
   // Clock
   input  wire logic aclk,
   // Token link
   output token_s    token,
   input  wire logic stall_request,
   output logic      stall_sent,
   input  wire logic set_rx_last,
   input  wire logic set_tx_done
);
   int stalls_seen;
   int flags_seen;
   int reply_gap;
   int gap_cnt;

   initial
   begin
      token = '0;
      stall_sent = 1'b0;
      stalls_seen = 0;
      flags_seen = 0;
      reply_gap = 0;
      gap_cnt = 0;
   end

   // One token per call, valid for a single cycle
   task automatic send(input token_e k);
      @(posedge aclk);
      token <= '{valid: 1'b1, kind: k};
      @(posedge aclk);
      token <= '{valid: 1'b0, kind: TOK_SETUP};
   endtask

   // Gap models a slow bus turnaround before the STALL leaves
   always @(posedge aclk)
   begin
      stall_sent <= (gap_cnt == 1);
      if (stall_request === 1'b1)
      begin
         stalls_seen <= stalls_seen + 1;
         gap_cnt <= reply_gap + 1;
      end
      else if (gap_cnt != 0)
         gap_cnt <= gap_cnt - 1;
      if (set_rx_last === 1'b1 && set_tx_done === 1'b1)
         flags_seen <= flags_seen + 1;
   end
endmodule
`default_nettype wire
